// [src/crms_sequencer.sv]
// Overview of operation
// R1: start sequence on enable rising edge
// R2: ramp to boot level 100 us later
// R3: force two-phase ccm during start-up
// R4: low slew current during boot ramp
// R5: clock enable after 13 in-window periods
// R6: fast slew and code target after clock
// R7: power good 7 ms after clock enable
// R8: regulate to seven-bit code target
// R9: code bit zero least significant
// R10: 12.5 mV per step, high codes zero
// R11: phases run half a period apart
// R12: ripple rate scales with active phases
// R13: strap forces single phase, phase two off
// R14: strap keeps diode emulation always on
// R15: active combos pick ccm by load
// R16: sleep high, deep low gives emulation
// R17: other combos pick ccm by load
// R18: emulation blocks low side at zero current
// R19: single phase waits for code ramp end
// R20: code change leaves emulation to two-phase
// R21: idle decision needs two stable periods
// R22: emulation decision needs seven stable periods
// R23: shift current, await zero before idling
// R24: trim phase one width to balance
// R25: compensation switch closed in single phase
// R26: filter counters restart on input change
`timescale 1ns/1ps
`default_nettype none
module crms_sequencer
  import crms_pkg::*;
#(
  parameter int DELAY_CYC = SOFT_DELAY_CYC,
  parameter int PG_CYC = POWER_GOOD_OUT_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic regulator_enable_in,
  input wire logic low_load_indicator_n,
  input wire logic sleep_slew_select,
  input wire logic deep_sleep_n,
  input wire logic [6:0] voltage_code,
  input wire logic phase2_strap,
  input wire logic vout_in_boot_window,
  input wire logic soft_at_target,
  input wire logic phase1_zero_current,
  input wire logic phase2_zero_current,
  input wire logic phase1_sense_high,
  input wire logic power_good_in,
  output logic power_good_out,
  output logic power_good_oe,
  output logic clk_en_n,
  output logic soft_ramp_en,
  output logic slew_fast,
  output logic [6:0] dac_code_q,
  output logic [13:0] target_q,
  output logic phase1_pulse_q,
  output logic phase2_pulse_q,
  output logic ripple_tick,
  output logic phase2_enable,
  output logic phase1_diode_emul,
  output logic lowside1_block,
  output logic current_shift,
  output logic comp_switch_closed,
  output logic phase1_width_up_q,
  output logic phase1_width_dn_q
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, cln_q;
  wire [NSYNC-1:0] pins = {power_good_in, phase1_sense_high, phase2_zero_current,
                           phase1_zero_current, soft_at_target, vout_in_boot_window,
                           phase2_strap, voltage_code, deep_sleep_n, sleep_slew_select,
                           low_load_indicator_n, regulator_enable_in};
  // a bit moves only once the second and third stages agree
  wire [NSYNC-1:0] cln_d = (s2_q & s3_q) | (cln_q & (s2_q | s3_q));

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      cln_q <= '0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      cln_q <= cln_d;
    end
  end

  wire en_s = cln_q[0];
  wire [2:0] combo_s = {cln_q[2], cln_q[3], cln_q[1]};
  wire [6:0] code_s = cln_q[10:4]; // R9
  wire strap_s = cln_q[11];
  wire window_s = cln_q[12];
  wire at_target_s = cln_q[13];
  wire z1_s = cln_q[14];
  wire z2_s = cln_q[15];
  wire i1_high_s = cln_q[16];
  wire pg_pin_s = cln_q[17];

  // ----------------------------------------------------------------
  // switching period base and interleaved pulses
  // ----------------------------------------------------------------
  logic [15:0] period_q, sw_cnt_q;
  wire sw_wrap = (sw_cnt_q >= period_q - 16'h0001);
  wire [15:0] half = {1'b0, period_q[15:1]};
  wire period_tick = sw_wrap;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sw_cnt_q <= 16'h0000;
      phase1_pulse_q <= 1'b0;
      phase2_pulse_q <= 1'b0;
    end
    else
    begin
      sw_cnt_q <= sw_wrap ? 16'h0000 : sw_cnt_q + 16'h0001;
      phase1_pulse_q <= (sw_cnt_q == 16'h0000);
      phase2_pulse_q <= phase2_enable && (sw_cnt_q == half); // R11
    end
  end

  // one ripple event per active phase per period
  assign ripple_tick = phase1_pulse_q | phase2_pulse_q; // R12

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  crms_seq_t seq_q, seq_d;
  logic [23:0] tmr_q, tmr_d;
  logic [3:0] boot_cnt_q, boot_cnt_d;
  logic en_prev_q;
  wire en_rise = en_s && !en_prev_q;
  wire boot_hit = period_tick && window_s && (boot_cnt_q == BOOT_QUAL_PERIODS - 4'h1);

  // next-state logic; dropping enable returns to off from anywhere
  always_comb
  begin
    seq_d = seq_q;
    tmr_d = tmr_q + 24'h000001;
    boot_cnt_d = boot_cnt_q;
    case (seq_q)
      SEQ_OFF:
      begin
        tmr_d = 24'h000000;
        if (en_rise)
          seq_d = SEQ_DELAY; // R1
      end
      SEQ_DELAY:
      begin
        if (tmr_q == 24'(DELAY_CYC - 1))
        begin
          seq_d = SEQ_BOOT; // R2
          boot_cnt_d = 4'h0;
        end
      end
      SEQ_BOOT:
      begin
        if (!window_s)
          boot_cnt_d = 4'h0;
        else if (period_tick)
          boot_cnt_d = boot_cnt_q + 4'h1;
        if (boot_hit)
        begin
          seq_d = SEQ_PGWAIT; // R5
          tmr_d = 24'h000000;
        end
      end
      SEQ_PGWAIT:
      begin
        if (tmr_q == 24'(PG_CYC - 1))
          seq_d = SEQ_RUN; // R7
      end
      SEQ_RUN:
        tmr_d = tmr_q;
      default:
        seq_d = SEQ_OFF;
    endcase
    if (!en_s)
      seq_d = SEQ_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      seq_q <= SEQ_OFF;
      tmr_q <= 24'h000000;
      boot_cnt_q <= 4'h0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      tmr_q <= tmr_d;
      boot_cnt_q <= boot_cnt_d;
      en_prev_q <= en_s;
    end
  end

  // sequence outputs
  assign soft_ramp_en = (seq_q == SEQ_BOOT) || slew_fast; // R2
  assign slew_fast = (seq_q == SEQ_PGWAIT) || (seq_q == SEQ_RUN); // R4 R6
  assign clk_en_n = !slew_fast; // R5
  assign power_good_out = 1'b0;
  assign power_good_oe = (seq_q != SEQ_RUN); // R7

  // ----------------------------------------------------------------
  // voltage target
  // ----------------------------------------------------------------
  logic [6:0] code_prev_q;
  logic ramp_busy_q;
  logic ramp_low_seen_q;
  wire code_change = slew_fast && (code_s != code_prev_q);
  wire [6:0] code_sel = slew_fast ? code_s : BOOT_CODE;
  // the at-target pin lags the code by the synchroniser, so its stale high
  // level must not end the ramp: it has to drop and come back first
  wire ramp_done = ramp_low_seen_q && at_target_s;

  // a new code sets the busy flag even in the cycle the ramp ends
  // limitation: a code change that never drops at-target keeps the drop blocked
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      code_prev_q <= 7'h00;
      ramp_busy_q <= 1'b0;
      ramp_low_seen_q <= 1'b0;
      dac_code_q <= 7'h00;
      target_q <= 14'h0000;
    end
    else
    begin
      code_prev_q <= code_s;
      ramp_low_seen_q <= !code_change && ramp_busy_q && (ramp_low_seen_q || !at_target_s); // R19
      ramp_busy_q <= code_change || (ramp_busy_q && !ramp_done); // R19
      dac_code_q <= code_sel; // R6 R8
      target_q <= crms_code_to_target(code_sel); // R8 R10
    end
  end

  // ----------------------------------------------------------------
  // operating mode selection
  // ----------------------------------------------------------------
  logic [2:0] f_idle, f_dcm;
  crms_glitch_filter #(.PERIODS(FILT_IDLE_PERIODS)) u_filt_idle
  (
    .clk(clk),
    .srst(srst),
    .period_tick(period_tick),
    .raw(combo_s),
    .stable_q(f_idle)
  );
  crms_glitch_filter #(.PERIODS(FILT_DCM_PERIODS)) u_filt_dcm
  (
    .clk(clk),
    .srst(srst),
    .period_tick(period_tick),
    .raw(combo_s),
    .stable_q(f_dcm)
  );

  // emulation only for sleep high with deep-sleep low, load ignored
  wire de_req = f_dcm[CMB_SLEEP] && !f_dcm[CMB_DEEP]; // R16 R22
  wire one_req = !f_idle[CMB_LOWLOAD]; // R15 R17 R21
  wire idle_de = f_idle[CMB_SLEEP] && !f_idle[CMB_DEEP];
  crms_mode_t mode_q, mode_d, want;
  assign want = de_req ? MD_1DE : ((one_req || idle_de) ? MD_1CCM : MD_2CCM);

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MD_2CCM:
        if (want != MD_2CCM && !ramp_busy_q && !code_change)
          mode_d = MD_DROP; // R19
      MD_DROP:
        if (want == MD_2CCM)
          mode_d = MD_2CCM;
        else if (z2_s)
          mode_d = want; // R23
      MD_1CCM:
        if (want == MD_2CCM)
          mode_d = MD_2CCM;
        else
          mode_d = want;
      MD_1DE:
        if (code_change || want == MD_2CCM)
          mode_d = MD_2CCM; // R20
        else
          mode_d = want;
      default:
        mode_d = MD_2CCM;
    endcase
    if (seq_q != SEQ_RUN)
      mode_d = MD_2CCM; // R3
    if (strap_s)
      mode_d = MD_1DE; // R13 R14
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      mode_q <= MD_2CCM;
    else
      mode_q <= mode_d;
  end

  // phase and compensation controls decoded from the mode register
  assign phase2_enable = (mode_q == MD_2CCM) || (mode_q == MD_DROP); // R13
  assign phase1_diode_emul = (mode_q == MD_1DE); // R14
  assign lowside1_block = phase1_diode_emul && z1_s; // R18
  assign current_shift = (mode_q == MD_DROP); // R23
  assign comp_switch_closed = !phase2_enable; // R25

  // ----------------------------------------------------------------
  // current balance trim
  // ----------------------------------------------------------------
  // only meaningful with both phases carrying current
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase1_width_up_q <= 1'b0;
      phase1_width_dn_q <= 1'b0;
    end
    else
    begin
      phase1_width_up_q <= phase2_enable && !i1_high_s; // R24
      phase1_width_dn_q <= phase2_enable && i1_high_s; // R24
    end
  end

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  wire hit_period = (paddr == REG_PERIOD);
  wire hit_status = (paddr == REG_STATUS);
  wire hit_target = (paddr == REG_TARGET);
  wire hit_code = (paddr == REG_CODE);
  wire mapped = hit_period | hit_status | hit_target | hit_code;
  wire setup = psel && !penable;
  wire wr_period = psel && penable && pwrite && hit_period;
  wire [31:0] status_word = (32'(seq_q) << ST_STATE_LSB) | (32'(mode_q) << ST_MODE_LSB)
                            | (32'(strap_s) << ST_STRAP_BIT) | (32'(pg_pin_s) << ST_POWER_GOOD_OUT_BIT);
  wire [31:0] rd_mux = hit_period ? {16'h0000, period_q} :
                       hit_status ? status_word :
                       hit_target ? {18'h00000, target_q} :
                       hit_code ? {25'h0000000, dac_code_q} : 32'h0000_0000;

  // read data is captured in the setup cycle, valid in the access cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      period_q <= SW_PERIOD_RST;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_period && pwdata[15:1] != 15'h0000)
        period_q <= pwdata[15:0];
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_enable_edge;
    (seq_q == SEQ_OFF) && en_rise && en_s;
  endsequence
  sequence s_boot_done;
    (seq_q == SEQ_BOOT) && boot_hit && en_s;
  endsequence

  property p_start;
    s_enable_edge |=> (seq_q == SEQ_DELAY) && (tmr_q == 24'h000000);
  endproperty
  a_start: assert property (p_start) // R1
    else $error("enable edge did not start the sequence");

  property p_delay;
    (seq_q == SEQ_DELAY) && $past(seq_q) != SEQ_DELAY |-> !soft_ramp_en [*2];
  endproperty
  a_delay: assert property (p_delay) // R2
    else $error("ramp started without the delay");

  property p_ramp_entry;
    $rose(soft_ramp_en) |-> $past(tmr_q) == 24'(DELAY_CYC - 1);
  endproperty
  a_ramp_entry: assert property (p_ramp_entry) // R2
    else $error("ramp started at the wrong delay count");

  property p_forced_ccm;
    (seq_q != SEQ_RUN) && !strap_s |=> phase2_enable || strap_s || seq_q == SEQ_RUN;
  endproperty
  a_forced_ccm: assert property (p_forced_ccm) // R3
    else $error("second phase idled during start-up");

  property p_slow_slew;
    (seq_q == SEQ_BOOT) |-> soft_ramp_en && !slew_fast && clk_en_n;
  endproperty
  a_slow_slew: assert property (p_slow_slew) // R4
    else $error("fast slew used on boot ramp");

  property p_clk_en;
    s_boot_done |=> !clk_en_n && slew_fast ##1 dac_code_q == $past(code_s);
  endproperty
  a_clk_en: assert property (p_clk_en) // R5 R6
    else $error("clock enable or slew switch missing after boot");

  property p_clk_en_cause;
    $fell(clk_en_n) |-> $past(boot_cnt_q) == BOOT_QUAL_PERIODS - 4'h1;
  endproperty
  a_clk_en_cause: assert property (p_clk_en_cause) // R5
    else $error("clock enable without 13 qualified periods");

  property p_power_good_out;
    $fell(power_good_oe) |-> $past(tmr_q) == 24'(PG_CYC - 1) && !clk_en_n;
  endproperty
  a_power_good_out: assert property (p_power_good_out) // R7
    else $error("power good at the wrong time");

  property p_strap;
    strap_s ##1 strap_s |=> !phase2_enable && phase1_diode_emul;
  endproperty
  a_strap: assert property (p_strap) // R13 R14
    else $error("strap did not hold single phase emulation");

  property p_vid_exit;
    (mode_q == MD_1DE) && code_change && !strap_s ##1 !strap_s |-> mode_q == MD_2CCM;
  endproperty
  a_vid_exit: assert property (p_vid_exit) // R20
    else $error("code change did not leave emulation");

  property p_drop_wait;
    (mode_q == MD_2CCM) && ramp_busy_q |=> mode_q != MD_DROP;
  endproperty
  a_drop_wait: assert property (p_drop_wait) // R19
    else $error("phase drop during code ramp");

  property p_comp;
    comp_switch_closed == ((mode_q == MD_1CCM) || (mode_q == MD_1DE));
  endproperty
  a_comp: assert property (p_comp) // R25
    else $error("compensation switch disagrees with phase count");
endmodule : crms_sequencer
`default_nettype wire

// [src/crms_pkg.sv]
`default_nettype none
package crms_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SOFT_DELAY_US = 100;
  localparam int T_POWER_GOOD_OUT_MS = 7;
  localparam int SOFT_DELAY_CYC = (T_SOFT_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int POWER_GOOD_OUT_CYC = (T_POWER_GOOD_OUT_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // sequencing counts, in switching periods; reset switching period length in clocks
  // ----------------------------------------------------------------
  localparam logic [3:0] BOOT_QUAL_PERIODS = 4'd13;
  localparam int FILT_IDLE_PERIODS = 2;
  localparam int FILT_DCM_PERIODS = 7;
  localparam logic [15:0] SW_PERIOD_RST = 16'h01A1;

  // ----------------------------------------------------------------
  // voltage code, target in units of 100 uV
  // ----------------------------------------------------------------
  localparam logic [6:0] BOOT_CODE = 7'h18;
  localparam logic [6:0] CODE_LAST_NONZERO = 7'h60;
  localparam logic [13:0] TARGET_TOP = 14'h3A98;
  localparam logic [13:0] TARGET_STEP = 14'h007D;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PERIOD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TARGET = 8'h08;
  localparam logic [7:0] REG_CODE = 8'h0C;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_STRAP_BIT = 8;
  localparam int ST_POWER_GOOD_OUT_BIT = 9;

  // ----------------------------------------------------------------
  // mode-control combination bit positions {sleep, deep_n, low_load_n}
  // ----------------------------------------------------------------
  localparam int CMB_LOWLOAD = 0;
  localparam int CMB_DEEP = 1;
  localparam int CMB_SLEEP = 2;

  typedef enum logic [2:0] {SEQ_OFF, SEQ_DELAY, SEQ_BOOT, SEQ_PGWAIT, SEQ_RUN} crms_seq_t;
  typedef enum logic [1:0] {MD_2CCM, MD_DROP, MD_1CCM, MD_1DE} crms_mode_t;

  // decode a voltage code to its target in 100 uV units
  function automatic logic [13:0] crms_code_to_target(input logic [6:0] code);
    logic [13:0] prod;
    prod = 14'(code) * TARGET_STEP;
    if (code > CODE_LAST_NONZERO)
      crms_code_to_target = 14'h0000;
    else
      crms_code_to_target = TARGET_TOP - prod;
  endfunction : crms_code_to_target
endpackage : crms_pkg
`default_nettype wire

// [src/crms_glitch_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module crms_glitch_filter
  import crms_pkg::*;
#(
  parameter int PERIODS = 2
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic period_tick,
  input wire logic [2:0] raw,
  output logic [2:0] stable_q
);
  // ----------------------------------------------------------------
  // qualification counter
  // ----------------------------------------------------------------
  // one extra tick is needed since the first tick after a change
  // closes only a partial period
  localparam logic [3:0] NEED = 4'(PERIODS + 1);
  logic [2:0] last_q;
  logic [3:0] cnt_q;
  wire changed = (raw != last_q);
  wire done = (cnt_q == NEED);

  // restart on every change of the sampled combination
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      last_q <= 3'h0;
      cnt_q <= 4'h0;
      stable_q <= 3'h0;
    end
    else
    begin
      last_q <= raw;
      if (changed)
        cnt_q <= 4'h0; // R26
      else if (period_tick && !done)
        cnt_q <= cnt_q + 4'h1;
      if (done)
        stable_q <= last_q; // R21 R22
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_short_ignored;
    @(posedge clk) disable iff (srst)
      (stable_q != $past(stable_q)) |-> $past(cnt_q) == NEED;
  endproperty
  a_short_ignored: assert property (p_short_ignored) // R21
    else $error("filtered level changed before qualification");
endmodule : crms_glitch_filter
`default_nettype wire

// [verification/crms_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// --------
// board and plant beside the sequencer
// --------
module crms_cpu_model
(
  input wire logic clk,
  input wire logic soft_ramp_en,
  input wire logic [6:0] dac_code_q,
  input wire logic current_shift,
  input wire logic phase2_enable,
  input wire logic power_good_out,
  input wire logic power_good_oe,
  output logic vout_in_boot_window,
  output logic soft_at_target,
  output logic phase1_zero_current,
  output logic phase2_zero_current,
  output logic phase1_sense_high,
  output logic power_good_in
);
  int ramp_q;
  int settle_q;
  int shift_q;
  logic [6:0] code_q;
  // ramp, code slew and decay of the idling phase, one step per clock
  always @(posedge clk)
  begin
    ramp_q <= soft_ramp_en ? ramp_q + 1 : 0;
    code_q <= dac_code_q;
    settle_q <= (code_q != dac_code_q) ? 200 : (settle_q > 0 ? settle_q - 1 : 0);
    shift_q <= current_shift ? shift_q + 1 : 0;
  end
  // a slow slew keeps the code ramp busy long enough to be seen
  assign vout_in_boot_window = ramp_q > 30;
  assign soft_at_target = settle_q == 0;
  assign phase2_zero_current = !phase2_enable || shift_q > 6;
  assign phase1_zero_current = ramp_q[2];
  assign phase1_sense_high = ramp_q[4];
  assign power_good_in = power_good_oe ? power_good_out : 1'b1; // pull-up on the open-drain wire
endmodule : crms_cpu_model
`default_nettype wire

// [verification/core_regulator_mode_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module core_regulator_mode_sequencer_tb_top;
  import crms_pkg::*;
  // --------
  // signals and bookkeeping
  // --------
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, phase2_strap = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic regulator_enable_in = 0, low_load_indicator_n = 1, sleep_slew_select = 0, deep_sleep_n = 1;
  logic [6:0] voltage_code = 7'h00;
  logic [31:0] prdata;
  logic [6:0] dac_code_q;
  logic [13:0] target_q;
  logic pready, pslverr, power_good_out, power_good_oe, clk_en_n, soft_ramp_en, slew_fast;
  logic phase1_pulse_q, phase2_pulse_q, ripple_tick, phase2_enable, phase1_diode_emul;
  logic lowside1_block, current_shift, comp_switch_closed, phase1_width_up_q, phase1_width_dn_q;
  logic vout_in_boot_window, soft_at_target, phase1_zero_current, phase2_zero_current;
  logic phase1_sense_high, power_good_in, err, bad;
  logic [31:0] rd;
  logic [6:0] c;
  logic [6:0] edge_codes [5] = '{7'h00, 7'h01, 7'h60, 7'h61, 7'h7F};
  int fail_count = 0, tests_run = 0, seed = 90, n;

  crms_sequencer #(.DELAY_CYC(20), .PG_CYC(50)) DUT (.*);
  crms_cpu_model cpu (.*);

  // bench clock, 8 ns period
  always #4 clk = ~clk;

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic hang();
    fail_count++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    end_of_test();
  endtask : hang

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // one apb transfer; waits an edge first so a release never meets a new setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (k == 20)
      hang();
  endtask : apb

  // register read, masked, with the error flag expected for places above REG_CODE
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_pin(rd & m, exp);
    chk_pin({31'h0, err}, {31'h0, a > REG_CODE});
  endtask : chk_reg

  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++)
      @(posedge clk);
    if (n == lim)
      hang();
  endtask : wait_for

  task automatic setc(input logic [2:0] k);
    {sleep_slew_select, deep_sleep_n, low_load_indicator_n} <= k;
  endtask : setc

  // reference model of mode selection and code decoding
  function automatic logic [1:0] exp_mode(input logic [2:0] k);
    if (phase2_strap || (k[CMB_SLEEP] && !k[CMB_DEEP]))
      return 2'd3;
    return k[CMB_LOWLOAD] ? 2'd0 : 2'd2;
  endfunction : exp_mode

  function automatic logic [13:0] exp_tgt(input int k);
    return k > 96 ? 14'h0000 : 14'(15000 - 125 * k);
  endfunction : exp_tgt

  task automatic chk_mode(input logic [2:0] k);
    logic [1:0] m;
    m = exp_mode(k);
    chk_reg(REG_STATUS, 32'h0000_0030, {26'h0, m, 4'h0});
    chk_pin(phase2_enable, m == 0);
    chk_pin(comp_switch_closed, m != 0);
    chk_pin(phase1_diode_emul, m == 3);
    chk_pin(lowside1_block && m != 3, 0);
  endtask : chk_mode

  // pulse counts over four periods of 16 clocks, from a phase-one pulse on
  task automatic chk_ripple(input int e2);
    int p1, p2, r, gap;
    p1 = 0;
    p2 = 0;
    r = 0;
    gap = 0;
    wait_for(phase1_pulse_q, 1, 20);
    repeat (64)
    begin
      @(posedge clk);
      gap = phase1_pulse_q ? 0 : gap + 1;
      p1 += phase1_pulse_q;
      p2 += (phase2_pulse_q && gap == 8);
      r += ripple_tick;
    end
    chk_pin(p1, 4);
    chk_pin(p2, e2);
    chk_pin(r, 4 + e2);
    chk_pin(phase1_width_up_q ^ phase1_width_dn_q, e2 != 0);
  endtask : chk_ripple

  // short pulse of a combination; the watched level must not move
  task automatic glitch(input logic [2:0] k, input int len, ref logic s, input logic v);
    bad = 0;
    setc(k);
    cyc(len);
    setc(3'b111);
    repeat (300)
    begin
      @(posedge clk);
      bad = bad | (s !== v);
    end
  endtask : glitch

  // --------
  // main sequence
  // --------
  initial
  begin
    cyc(6);
    srst <= 0;
    chk_reg(REG_PERIOD, 32'hFFFF_FFFF, 32'h0000_01A1);
    chk_reg(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, REG_PERIOD, 32'h0000_0001);
    chk_reg(REG_PERIOD, 32'hFFFF_FFFF, 32'h0000_01A1);
    apb(1'b1, REG_PERIOD, 32'h0000_0010);
    chk_reg(REG_PERIOD, 32'hFFFF_FFFF, 32'h0000_0010);
    setc(3'b100);
    voltage_code <= 7'h30;
    regulator_enable_in <= 1;
    cyc(20);
    chk_pin(soft_ramp_en, 0);
    wait_for(soft_ramp_en, 1, 40);
    chk_pin(slew_fast, 0);
    wait_for(vout_in_boot_window, 1, 100);
    cyc(190);
    chk_pin(clk_en_n, 1);
    wait_for(clk_en_n, 0, 30);
    cyc(2);
    chk_pin(slew_fast, 1);
    chk_pin(dac_code_q, 7'h30);
    chk_mode(3'b111);
    cyc(36);
    chk_pin(power_good_in, 0);
    wait_for(power_good_in, 1, 20);
    for (int i = 0; i < 8; i++)
    begin
      setc(3'(i + 4));
      cyc(400);
      chk_mode(3'(i + 4));
      chk_ripple(exp_mode(3'(i + 4)) == 0 ? 4 : 0);
    end
    setc(3'b101);
    cyc(400);
    voltage_code <= 7'h31;
    cyc(7);
    chk_pin(phase2_enable, 1);
    setc(3'b111);
    cyc(400);
    setc(3'b110);
    voltage_code <= 7'h20;
    cyc(150);
    chk_pin(phase2_enable, 1);
    cyc(250);
    chk_mode(3'b110);
    setc(3'b111);
    for (int i = 0; i < 11; i++)
    begin
      c = i < 5 ? edge_codes[i] : 7'($random(seed));
      voltage_code <= c;
      cyc(10);
      chk_pin(target_q, exp_tgt(c));
      chk_reg(REG_TARGET, 32'h0000_3FFF, {18'h0, exp_tgt(c)});
    end
    cyc(300);
    glitch(3'b110, 16, phase2_enable, 1);
    chk_pin(bad, 0);
    glitch(3'b101, 80, phase1_diode_emul, 0);
    chk_pin(bad, 0);
    phase2_strap <= 1;
    cyc(20);
    chk_mode(3'b111);
    regulator_enable_in <= 0;
    cyc(8);
    chk_pin({clk_en_n, power_good_oe, soft_ramp_en}, 3'b110);
    end_of_test();
  end
endmodule : core_regulator_mode_sequencer_tb_top
`default_nettype wire
